//--- shared/srx_regs.svh
// constants for the secure region exit sequencer
// assumes 64-bit linear addresses and a 48-bit implemented virtual range
`ifndef SRX_REGS_SVH
`define SRX_REGS_SVH

// implemented virtual address bits, canonical check covers the top implemented bit and all bits above it
`define SRX_VA_BITS            48
// error code carried by every general protection fault of the exit leaf
`define SRX_GP_ERR_CODE        32'h0000_0000
// field positions inside user_flow_protect_cfg
`define SRX_CFG_SHSTK_BIT      0
`define SRX_CFG_ENDBR_BIT      2
`define SRX_CFG_SUPPRESS_BIT   10
`define SRX_CFG_BRANCH_TARGET_A_BIT    11
// reset values
`define SRX_RST_ADDR           64'h0000_0000_0000_0000
`define SRX_RST_CODE           32'h0000_0000

`endif

//--- shared/srx_pkg.sv
// types for the secure region exit sequencer
// constants live in srx_regs.svh
package srx_pkg;

  // one data segment register, visible and hidden parts
  typedef struct packed {
    logic [15:0] selector;
    logic [63:0] base;
    logic [31:0] limit;
    logic [11:0] access;
  } srx_seg_t;

  // state captured at region entry, held by the core
  typedef struct packed {
    srx_seg_t    fs;
    srx_seg_t    gs;
    logic [63:0] ext_feature_ctrl_reg;
    logic        trap_flag;
    logic [63:0] user_flow_protect_cfg;
    logic [63:0] shadow_stack_pointer;
  } srx_saved_t;

  // feature and control bits sampled at the exit request
  typedef struct packed {
    logic os_ext_save_enable;
    logic cap_prev_shadow;
    logic cap_branch_track;
    logic cap_shadow_stack;
    logic cr_flow_protect_en;
    logic monitor_trap_flag;
  } srx_ctrl_t;

  // sequencer states
  typedef enum logic [0:0] {
    SRX_IDLE,
    SRX_MEM
  } srx_state_t;

endpackage

//--- hw/srx_exit_seq.sv
// secure region exit sequencer: checks the exit target, writes the thread
// control struct, then commits the restored outer state in one cycle.
// assumes saved copies and control inputs stay stable from request to done.
//
// Behaviour
// R01 - 64-bit mode: noncanonical target gives fault zero
// R02 - otherwise target above segment limit gives fault
// R03 - keep old pointer copy, load target
// R04 - return async exit pointer in counter register
// R05 - restore both data segments from saved copies
// R06 - reload extension control only when save enabled
// R07 - reload trap flag from saved value
// R08 - trap flag set pends single-step debug exception
// R09 - monitor trap control pends trap exit
// R10 - record shadow pointer into previous-pointer field
// R11 - restore user flow-protect configuration when supported
// R12 - restore shadow stack pointer when supported
// R13 - tracking enabled: await branch target, clear suppress
// R14 - clear region flag, mark thread inactive
// R15 - flush linear context at sequence end
// R16 - exit outside region gives fault zero
// R17 - faulting memory access raises page fault
// R18 - unsuppress breakpoints, trap, records, monitoring
// R19 - all faults checked before any commit
`timescale 1ns/1ps
`include "srx_regs.svh"

module srx_exit_seq
  import srx_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // leaf issue and region entry
  input  wire logic        i_exit_req,
  input  wire logic        i_region_enter,
  input  wire logic [63:0] i_target_addr,
  input  wire logic        i_mode64,
  input  wire logic [31:0] i_cs_limit,
  input  wire logic [63:0] i_cur_instr_ptr,
  // saved state and controls
  input  wire srx_saved_t  i_saved,
  input  wire srx_ctrl_t   i_ctrl,
  input  wire logic [63:0] i_async_exit_ptr,
  input  wire logic [63:0] i_cur_shadow_ptr,
  input  wire logic [63:0] i_cur_flow_cfg,
  // thread control struct write port
  output logic             o_mem_req,
  output logic             o_mem_store_prev,
  output logic [63:0]      o_mem_prev_shadow,
  input  wire logic        i_mem_ack,
  input  wire logic        i_mem_fault,
  input  wire logic [31:0] i_mem_fault_code,
  // restored architectural state
  output logic [63:0]      o_instr_ptr,
  output logic [63:0]      o_branch_rec_ip,
  output logic [63:0]      o_counter_reg,
  output srx_seg_t         o_fs,
  output srx_seg_t         o_gs,
  output logic [63:0]      o_ext_feature_ctrl_reg,
  output logic             o_ext_feature_wr,
  output logic             o_trap_flag,
  output logic [63:0]      o_user_flow_protect_cfg,
  output logic             o_flow_cfg_wr,
  output logic [63:0]      o_shadow_stack_pointer,
  output logic             o_shadow_wr,
  output logic             o_region_mode_flag,
  // events
  output logic             o_debug_pend,
  output logic             o_mtf_exit_pend,
  output logic             o_unsuppress,
  output logic             o_flush_linear,
  output logic             o_done,
  output logic             o_gp_fault,
  output logic             o_pf_fault,
  output logic [31:0]      o_fault_code
);

  // sequencer registers
  srx_state_t  state_q, state_d;      // current step
  logic [63:0] target_q;              // latched exit target
  logic [63:0] rec_ip_q;              // pointer copy for branch record
  logic        store_prev_q;          // previous-pointer write wanted
  logic        region_q;              // region mode flag

  // fault decode, evaluated only when a request is taken
  wire logic        upper_same  = (i_target_addr[63:`SRX_VA_BITS-1] == '0) ||
                                  (i_target_addr[63:`SRX_VA_BITS-1] == '1);
  wire logic        bad_canon   = i_mode64 && !upper_same;                      // R01
  wire logic        bad_limit   = !i_mode64 && (i_target_addr > {32'h0, i_cs_limit}); // R02
  wire logic        not_inside  = !region_q;                                    // R16
  wire logic        gp_hit      = not_inside || bad_canon || bad_limit;
  wire logic        take        = (state_q == SRX_IDLE) && i_exit_req;
  wire logic        go_mem      = take && !gp_hit;                              // R19
  wire logic        mem_ok      = (state_q == SRX_MEM) && i_mem_ack && !i_mem_fault;
  wire logic        mem_bad     = (state_q == SRX_MEM) && i_mem_ack && i_mem_fault;
  // previous pointer only with the capability and shadow stacks on
  wire logic        want_prev   = i_ctrl.cap_prev_shadow &&
                                  i_cur_flow_cfg[`SRX_CFG_SHSTK_BIT];           // R10
  // narrow mode keeps only a 32-bit copy of the current pointer
  wire logic [63:0] ip_copy     = i_mode64 ? i_cur_instr_ptr :
                                             {32'h0, i_cur_instr_ptr[31:0]};    // R03
  // flow-protect restore and branch_target_a update
  wire logic        flow_sup    = i_ctrl.cap_branch_track || i_ctrl.cap_shadow_stack;
  wire logic        track_on    = i_ctrl.cr_flow_protect_en &&
                                  i_saved.user_flow_protect_cfg[`SRX_CFG_ENDBR_BIT];
  logic      [63:0] flow_cfg;

  // when tracking is on, branch_target_a forced to awaiting_branch_target, suppress cleared
  always_comb begin
    flow_cfg = i_saved.user_flow_protect_cfg;                                   // R11
    if (track_on) begin
      flow_cfg[`SRX_CFG_BRANCH_TARGET_A_BIT]  = 1'b1;                                   // R13
      flow_cfg[`SRX_CFG_SUPPRESS_BIT] = 1'b0;                                   // R13
    end
  end

  // next step
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SRX_IDLE: begin
        if (go_mem) begin
          state_d = SRX_MEM;
        end
      end
      SRX_MEM: begin
        if (i_mem_ack) begin
          state_d = SRX_IDLE;
        end
      end
    endcase
  end

  // step register and request latch
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q      <= SRX_IDLE;
      target_q     <= `SRX_RST_ADDR;
      rec_ip_q     <= `SRX_RST_ADDR;
      store_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (go_mem) begin
        target_q     <= i_target_addr;
        rec_ip_q     <= ip_copy;                                                // R03
        store_prev_q <= want_prev;
      end
    end
  end

  // region flag: entry sets, successful exit clears
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      region_q <= 1'b0;
    end else if (mem_ok) begin
      region_q <= 1'b0;                                                         // R14
    end else if (i_region_enter) begin
      region_q <= 1'b1;
    end
  end

  // thread struct write: inactive state plus optional previous pointer;
  // a fault here leaves all registers untouched since commit waits for an ack without fault
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_mem_req         <= 1'b0;
      o_mem_store_prev  <= 1'b0;
      o_mem_prev_shadow <= `SRX_RST_ADDR;
    end else if (go_mem) begin
      o_mem_req         <= 1'b1;                                                // R14
      o_mem_store_prev  <= want_prev;                                           // R10
      o_mem_prev_shadow <= i_cur_shadow_ptr;                                    // R10
    end else if (i_mem_ack) begin
      o_mem_req         <= 1'b0;
      o_mem_store_prev  <= 1'b0;
    end
  end

  // commit of pointers, counter and segments, only after a clean write
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_instr_ptr     <= `SRX_RST_ADDR;
      o_branch_rec_ip <= `SRX_RST_ADDR;
      o_counter_reg   <= `SRX_RST_ADDR;
      o_fs            <= '0;
      o_gs            <= '0;
    end else if (mem_ok) begin                                                  // R19
      o_instr_ptr     <= target_q;                                              // R03
      o_branch_rec_ip <= rec_ip_q;                                              // R03
      o_counter_reg   <= i_async_exit_ptr;                                      // R04
      o_fs            <= i_saved.fs;                                            // R05
      o_gs            <= i_saved.gs;                                            // R05
    end
  end

  // commit of extension, trap and flow-protect state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_ext_feature_ctrl_reg  <= `SRX_RST_ADDR;
      o_ext_feature_wr        <= 1'b0;
      o_trap_flag             <= 1'b0;
      o_user_flow_protect_cfg <= `SRX_RST_ADDR;
      o_flow_cfg_wr           <= 1'b0;
      o_shadow_stack_pointer  <= `SRX_RST_ADDR;
      o_shadow_wr             <= 1'b0;
    end else begin
      o_ext_feature_wr <= mem_ok && i_ctrl.os_ext_save_enable;                  // R06
      o_flow_cfg_wr    <= mem_ok && flow_sup;                                   // R11
      o_shadow_wr      <= mem_ok && flow_sup && i_ctrl.cap_shadow_stack;        // R12
      if (mem_ok && i_ctrl.os_ext_save_enable) begin
        o_ext_feature_ctrl_reg <= i_saved.ext_feature_ctrl_reg;                 // R06
      end
      if (mem_ok) begin
        o_trap_flag <= i_saved.trap_flag;                                       // R07
      end
      if (mem_ok && flow_sup) begin
        o_user_flow_protect_cfg <= flow_cfg;                                    // R11
      end
      if (mem_ok && flow_sup && i_ctrl.cap_shadow_stack) begin
        o_shadow_stack_pointer <= i_saved.shadow_stack_pointer;                 // R12
      end
    end
  end

  // completion events, each a one-cycle pulse
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_debug_pend    <= 1'b0;
      o_mtf_exit_pend <= 1'b0;
      o_unsuppress    <= 1'b0;
      o_flush_linear  <= 1'b0;
      o_done          <= 1'b0;
    end else begin
      o_debug_pend    <= mem_ok && i_saved.trap_flag;                           // R08
      o_mtf_exit_pend <= mem_ok && i_ctrl.monitor_trap_flag;                    // R09
      o_unsuppress    <= mem_ok;                                                // R18
      o_flush_linear  <= mem_ok;                                                // R15
      o_done          <= mem_ok;
    end
  end

  // fault reporting; gp decided at request, page fault on write ack
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_gp_fault   <= 1'b0;
      o_pf_fault   <= 1'b0;
      o_fault_code <= `SRX_RST_CODE;
    end else begin
      o_gp_fault <= take && gp_hit;                                             // R16
      o_pf_fault <= mem_bad;                                                    // R17
      if (take && gp_hit) begin
        o_fault_code <= `SRX_GP_ERR_CODE;                                       // R01
      end else if (mem_bad) begin
        o_fault_code <= i_mem_fault_code;                                       // R17
      end
    end
  end

  assign o_region_mode_flag = region_q;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence req_gp_s;
    take && gp_hit;
  endsequence
  sequence clean_exit_s;
    // a stall longer than seven cycles is left unchecked here
    go_mem ##[1:8] mem_ok;
  endsequence

  canon_fault_a: assert property (take && bad_canon |=> o_gp_fault && o_fault_code == 32'h0) // R01
    else $error("noncanonical target not faulted");
  limit_fault_a: assert property (take && bad_limit |=> o_gp_fault)                          // R02
    else $error("target above limit not faulted");
  outside_fault_a: assert property (take && !region_q |=> o_gp_fault && !o_mem_req)          // R16
    else $error("exit outside region not faulted");
  gp_no_write_a: assert property (req_gp_s |=> state_q == SRX_IDLE && !o_done)              // R19
    else $error("faulting exit reached write");
  ip_load_a: assert property (clean_exit_s |=> o_instr_ptr == $past(target_q) && o_done)     // R03
    else $error("pointer not loaded from target");
  page_fault_a: assert property (mem_bad |=> o_pf_fault && !o_done && o_region_mode_flag)    // R17
    else $error("page fault mishandled");
  region_clear_a: assert property (o_done |-> !o_region_mode_flag && o_flush_linear)         // R14
    else $error("region flag not cleared at done");
  trap_pend_a: assert property (o_done && o_trap_flag |-> o_debug_pend)                      // R08
    else $error("single step not pended");
  track_set_a: assert property (mem_ok && flow_sup && track_on |=>                           // R13
      o_user_flow_protect_cfg[`SRX_CFG_BRANCH_TARGET_A_BIT] &&
      !o_user_flow_protect_cfg[`SRX_CFG_SUPPRESS_BIT])
    else $error("branch_target_a not set on exit");
  ext_keep_a: assert property (mem_ok && !i_ctrl.os_ext_save_enable |=>                      // R06
      $stable(o_ext_feature_ctrl_reg) && !o_ext_feature_wr)
    else $error("extension register changed while disabled");

endmodule

//--- verification/srx_exit_seq_tb_top.sv
// self-checking bench for the secure region exit sequencer
// assumes a 50 MHz clock, synchronous low reset and the hand-over timing
`timescale 1ns/1ps
`include "srx_regs.svh"

module srx_exit_seq_tb_top
  import srx_pkg::*;
;
  // clock, reset and leaf issue
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n, i_exit_req, i_region_enter, i_mode64;
  logic [63:0] i_target_addr, i_cur_instr_ptr, i_async_exit_ptr;
  logic [63:0] i_cur_shadow_ptr, i_cur_flow_cfg;
  logic [31:0] i_cs_limit, i_mem_fault_code;
  logic        i_mem_ack, i_mem_fault;
  srx_saved_t  i_saved;
  srx_ctrl_t   i_ctrl;
  // outputs of the design
  logic        o_mem_req, o_mem_store_prev, o_ext_feature_wr, o_trap_flag, o_flow_cfg_wr;
  logic        o_shadow_wr, o_region_mode_flag, o_debug_pend, o_mtf_exit_pend, o_unsuppress;
  logic        o_flush_linear, o_done, o_gp_fault, o_pf_fault;
  logic [63:0] o_mem_prev_shadow, o_instr_ptr, o_branch_rec_ip, o_counter_reg;
  logic [63:0] o_ext_feature_ctrl_reg, o_user_flow_protect_cfg, o_shadow_stack_pointer;
  logic [31:0] o_fault_code;
  srx_seg_t    o_fs, o_gs;
  // bench state: counters, random source, expected held registers
  int          n_fail = 0;
  int          cmp_count = 0;
  logic [31:0] lf = 32'h0000_0026;
  logic [63:0] e_ip, e_ext, e_cfg, e_ssp;
  logic        e_reg;

  srx_exit_seq srx_exit_seq_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_exit_req(i_exit_req),
    .i_region_enter(i_region_enter), .i_target_addr(i_target_addr), .i_mode64(i_mode64),
    .i_cs_limit(i_cs_limit), .i_cur_instr_ptr(i_cur_instr_ptr), .i_saved(i_saved),
    .i_ctrl(i_ctrl), .i_async_exit_ptr(i_async_exit_ptr), .i_cur_shadow_ptr(i_cur_shadow_ptr),
    .i_cur_flow_cfg(i_cur_flow_cfg), .o_mem_req(o_mem_req), .o_mem_store_prev(o_mem_store_prev),
    .o_mem_prev_shadow(o_mem_prev_shadow), .i_mem_ack(i_mem_ack), .i_mem_fault(i_mem_fault),
    .i_mem_fault_code(i_mem_fault_code), .o_instr_ptr(o_instr_ptr),
    .o_branch_rec_ip(o_branch_rec_ip), .o_counter_reg(o_counter_reg), .o_fs(o_fs), .o_gs(o_gs),
    .o_ext_feature_ctrl_reg(o_ext_feature_ctrl_reg), .o_ext_feature_wr(o_ext_feature_wr),
    .o_trap_flag(o_trap_flag), .o_user_flow_protect_cfg(o_user_flow_protect_cfg),
    .o_flow_cfg_wr(o_flow_cfg_wr), .o_shadow_stack_pointer(o_shadow_stack_pointer),
    .o_shadow_wr(o_shadow_wr), .o_region_mode_flag(o_region_mode_flag),
    .o_debug_pend(o_debug_pend), .o_mtf_exit_pend(o_mtf_exit_pend), .o_unsuppress(o_unsuppress),
    .o_flush_linear(o_flush_linear), .o_done(o_done), .o_gp_fault(o_gp_fault),
    .o_pf_fault(o_pf_fault), .o_fault_code(o_fault_code)
  );

  always #10 i_sys_clk = ~i_sys_clk;

  // inputs always change 1 ns after the rising edge
  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  task automatic rnd(output logic [63:0] r);
    lf = lfsr_next(lf);
    r[31:0] = lf;
    lf = lfsr_next(lf);
    r[63:32] = lf;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_vec(input logic [127:0] got, input logic [127:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // fault expected before any memory access
  function automatic logic exp_gp(input logic reg_on, input logic m64, input logic [63:0] t,
                                  input logic [31:0] lim);
    if (!reg_on) return 1'b1;
    if (m64) return !((&t[63:47]) || !(|t[63:47]));
    return t > {32'h0000_0000, lim};
  endfunction

  // restored user flow cfg, branch_target_a armed when tracking is on
  function automatic logic [63:0] exp_cfg(input logic [63:0] c, input logic en);
    if (en && c[`SRX_CFG_ENDBR_BIT]) begin
      c[`SRX_CFG_BRANCH_TARGET_A_BIT]  = 1'b1;
      c[`SRX_CFG_SUPPRESS_BIT] = 1'b0;
    end
    return c;
  endfunction

  // one exit attempt; region entry, fault and stall chosen by caller
  task automatic trial(input logic ent, input logic m64, input logic [63:0] t,
                       input logic [31:0] lim, input logic pf, input int stall);
    logic [63:0] w, cf;
    logic [511:0] big;
    logic gp, sup;
    int n;
    for (int i = 0; i < 8; i++) begin
      rnd(w);
      big[i*64 +: 64] = w;
    end
    i_saved = big[$bits(srx_saved_t)-1:0];
    rnd(w);
    i_ctrl = w[5:0];
    rnd(i_async_exit_ptr);
    rnd(i_cur_shadow_ptr);
    rnd(i_cur_flow_cfg);
    rnd(i_cur_instr_ptr);
    rnd(w);
    i_mem_fault_code = w[31:0];
    if (ent) begin
      i_region_enter = 1'b1;
      step();
      i_region_enter = 1'b0;
      step();
      e_reg = 1'b1;
    end
    i_mode64 = m64;
    i_target_addr = t;
    i_cs_limit = lim;
    gp = exp_gp(e_reg, m64, t, lim);
    i_exit_req = 1'b1;
    step();
    i_exit_req = 1'b0;
    n = 0;
    while (o_gp_fault !== 1'b1 && o_mem_req !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    if (gp) begin
      cmp_bit(o_gp_fault, 1'b1, "gp fault");
      cmp_vec(o_fault_code, `SRX_GP_ERR_CODE, "gp code");
      cmp_bit(o_mem_req, 1'b0, "no access on gp");
      cmp_vec(o_instr_ptr, e_ip, "ip kept on gp");
      cmp_bit(o_region_mode_flag, e_reg, "flag kept on gp");
      return;
    end
    cmp_bit(o_mem_req, 1'b1, "thread write");
    cmp_bit(o_mem_store_prev, i_ctrl.cap_prev_shadow & i_cur_flow_cfg[0], "prev store");
    if (o_mem_store_prev === 1'b1)
      cmp_vec(o_mem_prev_shadow, i_cur_shadow_ptr, "prev shadow");
    repeat (stall) step();
    cmp_bit(o_mem_req, 1'b1, "write held");
    i_mem_ack = 1'b1;
    i_mem_fault = pf;
    step();
    i_mem_ack = 1'b0;
    i_mem_fault = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && o_pf_fault !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    if (pf) begin
      cmp_bit(o_pf_fault, 1'b1, "page fault");
      cmp_vec(o_fault_code, i_mem_fault_code, "pf code");
      cmp_bit(o_done, 1'b0, "no done on pf");
      cmp_vec(o_instr_ptr, e_ip, "ip kept on pf");
      cmp_bit(o_region_mode_flag, 1'b1, "flag kept on pf");
      return;
    end
    sup = i_ctrl.cap_branch_track | i_ctrl.cap_shadow_stack;
    cf = exp_cfg(i_saved.user_flow_protect_cfg, i_ctrl.cr_flow_protect_en);
    e_ip = t;
    if (i_ctrl.os_ext_save_enable) e_ext = i_saved.ext_feature_ctrl_reg;
    if (sup) e_cfg = cf;
    if (i_ctrl.cap_shadow_stack) e_ssp = i_saved.shadow_stack_pointer;
    e_reg = 1'b0;
    cmp_bit(o_done, 1'b1, "done");
    cmp_vec(o_instr_ptr, t, "ip load");
    cmp_vec(o_branch_rec_ip, m64 ? i_cur_instr_ptr : {32'h0, i_cur_instr_ptr[31:0]}, "rec ip");
    cmp_vec(o_counter_reg, i_async_exit_ptr, "counter reg");
    cmp_vec(o_fs, i_saved.fs, "fs restore");
    cmp_vec(o_gs, i_saved.gs, "gs restore");
    cmp_bit(o_ext_feature_wr, i_ctrl.os_ext_save_enable, "ext write");
    cmp_vec(o_ext_feature_ctrl_reg, e_ext, "ext value");
    cmp_bit(o_trap_flag, i_saved.trap_flag, "trap flag");
    cmp_bit(o_debug_pend, i_saved.trap_flag, "debug pend");
    cmp_bit(o_mtf_exit_pend, i_ctrl.monitor_trap_flag, "trap exit pend");
    cmp_bit(o_flow_cfg_wr, sup, "cfg write");
    cmp_vec(o_user_flow_protect_cfg, e_cfg, "cfg value");
    cmp_bit(o_shadow_wr, i_ctrl.cap_shadow_stack, "shadow write");
    cmp_vec(o_shadow_stack_pointer, e_ssp, "shadow value");
    cmp_bit(o_region_mode_flag, 1'b0, "region flag");
    cmp_bit(o_flush_linear, 1'b1, "flush");
    cmp_bit(o_unsuppress, 1'b1, "unsuppress");
    step();
    cmp_bit(o_mem_req, 1'b0, "write released");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: some 80 trials of under 30 cycles each, with ample margin
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  // main sequence: corners first, then random trials
  initial begin
    logic [63:0] r, t;
    {i_rst_n, i_exit_req, i_region_enter, i_mode64, i_mem_ack, i_mem_fault} = '0;
    {i_target_addr, i_cur_instr_ptr, i_async_exit_ptr, i_cur_shadow_ptr} = '0;
    {i_cur_flow_cfg, i_cs_limit, i_mem_fault_code, i_saved, i_ctrl} = '0;
    {e_ip, e_ext, e_cfg, e_ssp, e_reg} = '0;
    repeat (6) step();
    i_rst_n = 1'b1;
    trial(1'b0, 1'b1, 64'h0000_0000_0000_1000, 32'h0000_ffff, 1'b0, 0);
    trial(1'b1, 1'b1, 64'h0000_7fff_ffff_ffff, 32'h0000_ffff, 1'b0, 0);
    trial(1'b1, 1'b1, 64'h0000_8000_0000_0000, 32'h0000_ffff, 1'b0, 0);
    trial(1'b0, 1'b1, 64'hffff_8000_0000_0000, 32'h0000_ffff, 1'b1, 2);
    trial(1'b0, 1'b0, 64'h0000_0000_0001_0000, 32'h0000_ffff, 1'b0, 0);
    trial(1'b0, 1'b0, 64'h0000_0000_0000_ffff, 32'h0000_ffff, 1'b0, 1);
    $display("corner tests done");
    for (int k = 0; k < 72; k++) begin
      rnd(r);
      rnd(t);
      if (r[1]) t = {{16{t[47]}}, t[47:0]};
      if (!r[2]) t = {32'h0, t[31:0]};
      trial(r[5:3] != 3'h0, r[0], t, r[63:32], r[8:6] == 3'h0, int'(r[10:9]));
      $display("random test %0d done", k);
    end
    report_and_stop();
  end

endmodule
